// ### dbp_pkg.sv
// Operation
// - strobe style: read strobe fall, capture at rise
// - strobe style: hold write data through rise
// - strobe style: one active-low select per channel
// - force input kept low in direction style
package dbp_pkg;
    // ----------------------------------------------------------------
    // bus timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned SETUP_NS       = 16;
    localparam int unsigned STROBE_NS      = 48;
    localparam int unsigned RECOVER_NS     = 32;
    localparam int unsigned SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 4;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int unsigned REG_ADDR_W     = 3;
    localparam int unsigned CHAN_W         = 2;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned NUM_CHAN       = 4;
    localparam logic [3:0]  SEL_IDLE       = 4'hF;

    typedef enum logic [1:0] {
        DBP_IDLE    = 2'b00,
        DBP_SETUP   = 2'b01,
        DBP_STROBE  = 2'b10,
        DBP_RECOVER = 2'b11
    } dbp_state_t;
endpackage : dbp_pkg

// ### dbp_host_port.sv
`timescale 1ns/100ps
module dbp_host_port (
    input  wire logic                          i_mclk,         // 125 MHz clock
    input  wire logic                          i_srst,         // sync reset, high
    input  wire logic                          i_bus_style,    // 1 strobe style, 0 direction
    input  wire logic                          i_req_valid,    // access request
    output logic                               o_req_ready,    // request taken
    input  wire logic                          i_req_write,    // 1 write, 0 read
    input  wire logic [dbp_pkg::CHAN_W-1:0]    i_req_chan,     // channel 0..3
    input  wire logic [dbp_pkg::REG_ADDR_W-1:0] i_req_addr,    // register index
    input  wire logic [dbp_pkg::DATA_W-1:0]    i_req_wdata,    // write byte
    output logic                               o_rsp_valid,    // access done pulse
    output logic [dbp_pkg::DATA_W-1:0]         o_rsp_rdata,    // read byte
    input  wire logic                          i_irq_force,    // drive force level
    output logic                               o_irq_force,    // force pin level
    output logic [dbp_pkg::REG_ADDR_W-1:0]     o_reg_addr,     // address lines
    output logic                               o_read_strobe_n, // read strobe pin
    output logic                               o_write_strobe_n, // write / direction pin
    output logic                               o_channel_a_select_n, // select A / device
    output logic                               o_channel_b_select_n, // select B / addr low
    output logic                               o_channel_c_select_n, // select C / addr high
    output logic                               o_channel_d_select_n, // select D
    input  wire logic [dbp_pkg::DATA_W-1:0]    i_data,         // data bus in
    output logic [dbp_pkg::DATA_W-1:0]         o_data,         // data bus out
    output logic                               o_data_oe_n,    // low while driving
    input  wire logic [dbp_pkg::NUM_CHAN-1:0]  i_irq_pins,     // irq pin levels
    output logic [dbp_pkg::NUM_CHAN-1:0]       o_irq_pending   // per-channel pending
);
    import dbp_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // every phase needs at least one cycle, and the down-counter must
    // be wide enough to be loaded with the longest phase count minus one
    localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

    generate
        if ((SETUP_CYC < 1) || (STROBE_CYC < 1) || (RECOVER_CYC < 1)) begin : g_bad_phase
            $error("bus phase counts must be at least one cycle");
        end
        if ((SETUP_CYC - 1 > CNT_MAX) || (STROBE_CYC - 1 > CNT_MAX)
                || (RECOVER_CYC - 1 > CNT_MAX)) begin : g_bad_cnt
            $error("phase counter too narrow for the phase counts");
        end
        // the pin mapping below is written for four channels on two address bits
        if ((NUM_CHAN != 4) || (CHAN_W != 2)) begin : g_bad_chan
            $error("pin mapping serves exactly four channels");
        end
        // read data passes the synchroniser, so the strobe must outlast it
        // or a stale byte would be taken at the last strobe cycle
        if (STROBE_CYC < 3) begin : g_bad_strobe
            $error("read strobe shorter than the data synchroniser");
        end
    endgenerate

    // ----------------------------------------------------------------
    // synchronisers for pins from the device
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]   data_s1_q, data_s2_q;
    logic [NUM_CHAN-1:0] irq_s1_q, irq_s2_q;

    always_ff @(posedge i_mclk) begin
        data_s1_q <= i_data;
        data_s2_q <= data_s1_q;
        irq_s1_q  <= i_irq_pins;
        irq_s2_q  <= irq_s1_q;
    end

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    dbp_state_t              state_q, state_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic                    style_q, style_d;
    logic                    wr_q, wr_d;
    logic [CHAN_W-1:0]       chan_q, chan_d;
    logic [REG_ADDR_W-1:0]   addr_q, addr_d;
    logic [DATA_W-1:0]       wdata_q, wdata_d;
    logic [DATA_W-1:0]       rdata_q, rdata_d;
    logic                    rsp_q, rsp_d;
    logic                    force_q, force_d;

    assign o_req_ready = (state_q == DBP_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        style_d = style_q;
        wr_d    = wr_q;
        chan_d  = chan_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rsp_d   = 1'b0;
        // force may only be raised in strobe style
        force_d = i_irq_force & i_bus_style;
        case (state_q)
            DBP_IDLE: begin
                if (i_req_valid) begin
                    style_d = i_bus_style;
                    wr_d    = i_req_write;
                    chan_d  = i_req_chan;
                    addr_d  = i_req_addr;
                    wdata_d = i_req_wdata;
                    cnt_d   = CNT_W'(SETUP_CYC - 1);
                    state_d = DBP_SETUP;
                end
            end
            DBP_SETUP: begin
                if (cnt_q == '0) begin
                    cnt_d   = CNT_W'(STROBE_CYC - 1);
                    state_d = DBP_STROBE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            DBP_STROBE: begin
                if (cnt_q == '0) begin
                    // sample just before the strobe rises
                    if (!wr_q) begin
                        rdata_d = data_s2_q;
                    end
                    cnt_d   = CNT_W'(RECOVER_CYC - 1);
                    state_d = DBP_RECOVER;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            DBP_RECOVER: begin
                if (cnt_q == '0) begin
                    rsp_d   = 1'b1;
                    state_d = DBP_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = DBP_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_q <= DBP_IDLE;
            cnt_q   <= '0;
            style_q <= 1'b1;
            wr_q    <= 1'b0;
            chan_q  <= '0;
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rsp_q   <= 1'b0;
            force_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            style_q <= style_d;
            wr_q    <= wr_d;
            chan_q  <= chan_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rsp_q   <= rsp_d;
            force_q <= force_d;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    logic busy;
    logic strobe;
    logic [NUM_CHAN-1:0] chan_sel_n;

    assign busy   = (state_q != DBP_IDLE);
    assign strobe = (state_q == DBP_STROBE);

    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_sel
            assign chan_sel_n[g] = ~(busy && (chan_q == CHAN_W'(g)));
        end
    endgenerate

    always_comb begin
        o_reg_addr  = addr_q;
        o_data      = wdata_q;
        // data held from setup through recovery so it spans the rising edge
        o_data_oe_n = ~(busy && wr_q);
        if (style_q) begin
            o_read_strobe_n      = ~(strobe && !wr_q);
            o_write_strobe_n     = ~(strobe && wr_q);
            o_channel_a_select_n = chan_sel_n[0];
            o_channel_b_select_n = chan_sel_n[1];
            o_channel_c_select_n = chan_sel_n[2];
            o_channel_d_select_n = chan_sel_n[3];
        end else begin
            // unused read strobe parked high; direction held for whole select
            o_read_strobe_n      = 1'b1;
            o_write_strobe_n     = ~wr_q;
            o_channel_a_select_n = ~strobe;
            o_channel_b_select_n = chan_q[0];
            o_channel_c_select_n = chan_q[1];
            o_channel_d_select_n = 1'b1;
        end
    end

    assign o_rsp_valid = rsp_q;
    assign o_rsp_rdata = rdata_q;
    assign o_irq_force = force_q;

    // ----------------------------------------------------------------
    // interrupt pin interpretation
    // ----------------------------------------------------------------
    // floated pins are assumed pulled low on the board, so in strobe style high means pending
    always_comb begin
        if (i_bus_style) begin
            o_irq_pending = irq_s2_q;
        end else begin
            // shared active-low line; B..D read as constant zero
            o_irq_pending = {{(NUM_CHAN-1){1'b0}}, ~irq_s2_q[0]};
        end
    end
endmodule : dbp_host_port

// ### dbp_host_port_chk.sv
`timescale 1ns/100ps
module dbp_host_port_chk (
    input wire logic       i_mclk,
    input wire logic       i_srst,
    input wire logic       i_bus_style,
    input wire logic       i_req_valid,
    input wire logic       o_req_ready,
    input wire logic       o_rsp_valid,
    input wire logic       o_irq_force,
    input wire logic [2:0] o_reg_addr,
    input wire logic       o_read_strobe_n,
    input wire logic       o_write_strobe_n,
    input wire logic       o_channel_a_select_n,
    input wire logic       o_channel_b_select_n,
    input wire logic       o_channel_c_select_n,
    input wire logic       o_channel_d_select_n,
    input wire logic [7:0] o_data,
    input wire logic       o_data_oe_n,
    input wire logic [3:0] o_irq_pending
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    wire logic [3:0] sel_n = {o_channel_d_select_n, o_channel_c_select_n,
                              o_channel_b_select_n, o_channel_a_select_n};
    a_rd_width: assert property ($fell(o_read_strobe_n) |->
        !o_read_strobe_n [*6] ##1 o_read_strobe_n) else $error("read strobe width");
    a_take_answer: assert property (i_req_valid && o_req_ready |=>
        !o_rsp_valid [*8] ##[1:5] o_rsp_valid) else $error("access answer late");
    a_one_select: assert property (i_bus_style && !(o_read_strobe_n && o_write_strobe_n)
        |-> $onehot(~sel_n)) else $error("select not one-hot");
    a_wr_hold: assert property (i_bus_style && $rose(o_write_strobe_n) && !(&sel_n)
        |-> !o_data_oe_n && $stable(o_data)) else $error("write data dropped");
    a_dir_pins: assert property (!i_bus_style && !o_channel_a_select_n
        |-> o_read_strobe_n && o_channel_d_select_n) else $error("unused pins moved");
    a_force_low: assert property (!i_bus_style [*2] |-> !o_irq_force)
        else $error("force high in direction style");
    a_dir_irq: assert property (!i_bus_style |-> o_irq_pending[3:1] == 3'h0)
        else $error("spare irq pending");
    a_dir_hold: assert property (!i_bus_style && !o_channel_a_select_n |=>
        o_channel_a_select_n || $stable({o_reg_addr, o_write_strobe_n, sel_n[2:1]}))
        else $error("address moved while selected");
endmodule : dbp_host_port_chk
bind dbp_host_port dbp_host_port_chk u_chk (.*);

// ### dbp_uart_model.sv
`timescale 1ns/100ps
module dbp_uart_model (
    input  wire logic       i_bus_style,      // 1 strobe, 0 direction
    input  wire logic       i_read_strobe_n,  // read strobe
    input  wire logic       i_write_strobe_n, // write strobe or direction
    input  wire logic [3:0] i_select_n,       // selects d,c,b,a
    input  wire logic [2:0] i_reg_addr,       // register index
    input  wire logic [7:0] i_data,           // bus level
    input  wire logic       i_irq_force,      // force pin
    output logic      [7:0] o_data,           // device drive
    output logic      [3:0] o_irq_pins        // irq pin levels
);
    logic [7:0] mem [4][8] = '{default: 8'h00};
    logic [7:0] last_q = 8'h00;
    logic [1:0] ch;
    logic       rd;
    // undriven force reads low; a tied level behaves like a driven one
    wire logic  frc = (i_irq_force === 1'b1);
    always_comb begin
        ch = {i_select_n[2], i_select_n[1]};
        if (i_bus_style) begin
            if (!i_select_n[3]) begin
                ch = 2'd3;
            end else if (!i_select_n[2]) begin
                ch = 2'd2;
            end else begin
                ch = {1'b0, i_select_n[0]};
            end
        end
        rd = i_bus_style ? !i_read_strobe_n && !(&i_select_n)
                         : !i_select_n[0] && i_write_strobe_n;
        // released bus shows the inverse, so a stale sample cannot match
        o_data = rd ? mem[ch][i_reg_addr] : ~last_q;
        for (int c = 0; c < 4; c++) begin
            // floated pins sit at the board pull-down
            o_irq_pins[c] = i_bus_style & mem[c][1][0]
                            & (frc | mem[c][4][3]);
        end
        if (!i_bus_style) begin
            o_irq_pins = {3'b000, ~(mem[0][1][0] | mem[1][1][0]
                                    | mem[2][1][0] | mem[3][1][0])};
        end
    end
    always @(negedge rd) last_q <= mem[ch][i_reg_addr];
    // single writer: strobe rise in strobe style, select rise in direction style
    always @(posedge i_write_strobe_n or posedge i_select_n[0]) begin
        if (i_bus_style ? (i_write_strobe_n && !(&i_select_n)) : !i_write_strobe_n) begin
            mem[ch][i_reg_addr] <= i_data;
        end
    end
endmodule : dbp_uart_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
    logic i_mclk = 0, i_srst = 1, i_bus_style = 1, i_req_valid = 0, i_req_write = 0;
    logic i_irq_force = 0, o_req_ready, o_rsp_valid, o_irq_force, o_read_strobe_n;
    logic o_write_strobe_n, o_channel_a_select_n, o_channel_b_select_n;
    logic o_channel_c_select_n, o_channel_d_select_n, o_data_oe_n;
    logic [1:0] i_req_chan = 0, c;
    logic [2:0] i_req_addr = 0, a, o_reg_addr;
    logic [7:0] i_req_wdata = 0, d, o_rsp_rdata, o_data, dev_data, i_data;
    logic [7:0] shadow [4][8] = '{default: 8'h00};
    logic [3:0] i_irq_pins, o_irq_pending;
    int seed = 34093, num_errors = 0, checks_done = 0;
    assign i_data = o_data_oe_n ? dev_data : o_data;
    dbp_host_port u_dut (.*);
    dbp_uart_model u_dev (.i_bus_style, .i_read_strobe_n(o_read_strobe_n),
        .i_write_strobe_n(o_write_strobe_n), .i_select_n({o_channel_d_select_n,
        o_channel_c_select_n, o_channel_b_select_n, o_channel_a_select_n}),
        .i_reg_addr(o_reg_addr), .i_data, .i_irq_force(o_irq_force),
        .o_data(dev_data), .o_irq_pins(i_irq_pins));
    initial forever #4 i_mclk = ~i_mclk;
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [7:0] exp_irq(input logic s, input logic f);
        logic [3:0] e;
        e = 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (s) e[k] = shadow[k][1][0] & (f | shadow[k][4][3]);
            else e[0] = e[0] | shadow[k][1][0];
        end
        return {4'h0, e};
    endfunction : exp_irq
    task automatic acc(input logic w, input logic [1:0] ch, input logic [2:0] ad,
                       input logic [7:0] wd);
        int n;
        n = 0;
        {i_req_write, i_req_chan, i_req_addr, i_req_wdata} = {w, ch, ad, wd};
        i_req_valid = 1;
        @(posedge i_mclk);
        #1 i_req_valid = 0;
        while (o_rsp_valid !== 1'b1 && n < 30) begin
            @(posedge i_mclk);
            #1 n++;
        end
        if (n >= 30) chk("access done", 8'h01, 8'h00);
        if (w) shadow[ch][ad] = wd;
        else chk("read byte", shadow[ch][ad], o_rsp_rdata);
    endtask : acc
    initial begin
        repeat (3) @(posedge i_mclk);
        #1 i_srst = 0;
        for (int s = 1; s >= 0; s--) begin
            i_bus_style = s[0];
            acc(1'b1, 2'd3, 3'd7, 8'hFF);
            acc(1'b0, 2'd3, 3'd7, 8'h00);
            repeat (16) begin
                c = 2'($random(seed));
                a = 3'($random(seed));
                d = 8'($random(seed));
                acc(1'b1, c, a, d);
                acc(1'b0, c, a, 8'h00);
            end
            for (int k = 0; k < 8; k++) begin
                i_irq_force = k[0];
                acc(1'b1, k[1:0], 3'd1, 8'($random(seed)));
                acc(1'b1, k[2:1], 3'd4, 8'($random(seed)));
                repeat (5) @(posedge i_mclk);
                #1 chk("irq", exp_irq(s[0], k[0]), {4'h0, o_irq_pending});
            end
            $display("style %0d done", s);
        end
        close_out();
    end
    initial begin
        #(20000 * 8);
        num_errors++;
        $display("[ERR] watchdog expected done seen hang");
        close_out();
    end
endmodule : testbench
